//--- logic/amc_top.sv
// Acquisition mode control, peak temperature and reboot sequencing
// Operation
// - Peak temperature: signed 12 bits, low nibble reserved
// - Peak clears at reset or zero write
// - Bit 7 picks barometer or altimeter
// - Oversample ratio is two to field
// - Sample spacing follows oversample code table
// - Bit 2 starts reboot, reads zero
// - Active reboot goes standby first
// - Reboot resets and reloads all registers
// - Reboot also resets the serial logic
// - Reboot bit self-clears when boot ends
// - Active one-shot measures now, bit stays
// - Standby one-shot measures, clears, returns standby
// - Bit 0 selects standby or periodic active
// - Active period is two to exponent seconds
`timescale 1ns/1ps
`include "amc_defs.svh"
module amc_top #(
	parameter logic [6:0] DEV_ADDR = `AMC_I2C_ADDR_DEF,
	parameter int unsigned MS_CYCLES = `AMC_CLK_HZ / `AMC_MS_PER_S,
	parameter int unsigned S_CYCLES = `AMC_CLK_HZ * `AMC_STEP_BASE_S
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Serial link pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Step exponent from the step register
	input wire logic [3:0] acquisition_interval_exp_in,
	// Measurement engine
	input wire logic meas_done_in,
	input wire logic [11:0] meas_temp_in,
	output logic meas_start_out,
	// Mode outputs
	output logic run_active_out,
	output logic height_mode_out,
	output logic [7:0] oversample_ratio_out,
	output logic booting_out
);
	// ****************************************************
	// Storage
	// ****************************************************
	amc_if bus_if(); // Slave to register file
	amc_pkg::amc_state_t state; // Sequencer state
	logic height_mode_select; // Altimeter when set
	logic [2:0] oversample_field; // Oversample code
	logic single_shot_trigger; // One-shot request bit
	logic run_enable; // Active when set
	logic boot_req; // Reboot pending or running
	logic shot_kick; // Fresh one-shot in active mode
	logic oneshot_sb; // Current measurement is a standby shot
	logic [7:0] peak_hi; // Peak integer degrees
	logic [3:0] peak_lo; // Peak fraction
	logic [47:0] elapsed; // Cycles since last start
	logic [7:0] boot_cnt; // Reboot length counter
	logic [47:0] spacing_cycles; // Least spacing for this code
	logic [47:0] interval_cycles; // Active period in cycles
	logic wr_ctrl; // Host writes control word one
	logic [7:0] ctrl_view; // Control word one as read
	logic shot_clear; // Standby shot is finishing
	logic peak_take; // New reading beats the peak
	logic ready_state; // Standby or active, no work running

	// ****************************************************
	// Serial slave
	// ****************************************************
	amc_i2c #(
		.DEV_ADDR(DEV_ADDR)
	) u_i2c (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_out(sda_oe_out),
		.bus(bus_if.slave)
	);

	// Serial logic held in reset through reboot
	assign bus_if.soft_rst = (state == amc_pkg::AMC_REBOOT);

	// ****************************************************
	// Timing targets
	// ****************************************************
	// Least sample spacing in ms per oversample code
	function automatic logic [9:0] amc_space_ms(input logic [2:0] code);
		case (code)
			3'h0: amc_space_ms = 10'(`AMC_SPACE_MS_0);
			3'h1: amc_space_ms = 10'(`AMC_SPACE_MS_1);
			3'h2: amc_space_ms = 10'(`AMC_SPACE_MS_2);
			3'h3: amc_space_ms = 10'(`AMC_SPACE_MS_3);
			3'h4: amc_space_ms = 10'(`AMC_SPACE_MS_4);
			3'h5: amc_space_ms = 10'(`AMC_SPACE_MS_5);
			3'h6: amc_space_ms = 10'(`AMC_SPACE_MS_6);
			default: amc_space_ms = 10'(`AMC_SPACE_MS_7);
		endcase
	endfunction : amc_space_ms

	assign spacing_cycles = 48'(amc_space_ms(oversample_field))
		* 48'(MS_CYCLES);
	assign interval_cycles = 48'(S_CYCLES)
		<< acquisition_interval_exp_in;

	// ****************************************************
	// Decode helpers
	// ****************************************************
	assign wr_ctrl = bus_if.wr && (bus_if.addr == `AMC_ADDR_CTRL1);
	assign shot_clear = (state == amc_pkg::AMC_SPACING) && oneshot_sb
		&& (elapsed >= spacing_cycles);
	assign peak_take = (state == amc_pkg::AMC_MEASURE) && meas_done_in
		&& ($signed(meas_temp_in) > $signed({peak_hi, peak_lo}));
	assign ready_state = (state == amc_pkg::AMC_STANDBY)
		|| (state == amc_pkg::AMC_ACTIVE);
	assign height_mode_out = height_mode_select;
	assign booting_out = boot_req;

	// Control word one as software reads it
	always_comb begin
		ctrl_view = `AMC_READ_ZERO;
		ctrl_view[`AMC_CTRL_HEIGHT] = height_mode_select;
		ctrl_view[`AMC_CTRL_OS_HI:`AMC_CTRL_OS_LO] = oversample_field;
		ctrl_view[`AMC_CTRL_SHOT] = single_shot_trigger;
		ctrl_view[`AMC_CTRL_RUN] = run_enable;
	end

	// Read mux; reserved and unmapped bits read zero
	always_comb begin
		bus_if.rdata = `AMC_READ_ZERO;
		if (bus_if.addr == `AMC_ADDR_PEAK_HI) begin
			bus_if.rdata = peak_hi;
		end else if (bus_if.addr == `AMC_ADDR_PEAK_LO) begin
			bus_if.rdata[`AMC_PEAK_FRAC_HI:`AMC_PEAK_FRAC_LO] = peak_lo;
		end else if (bus_if.addr == `AMC_ADDR_CTRL1) begin
			bus_if.rdata = ctrl_view;
		end
	end

	// ****************************************************
	// Control word one
	// ****************************************************
	// Host writes win over hardware clears in the same cycle
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			height_mode_select <= 1'b0;
			oversample_field <= 3'h0;
			single_shot_trigger <= 1'b0;
			run_enable <= 1'b0;
			boot_req <= 1'b0;
			shot_kick <= 1'b0;
		end else if (state == amc_pkg::AMC_REBOOT) begin
			// Reload defaults; drop the request at the end
			height_mode_select <= 1'b0;
			oversample_field <= 3'h0;
			single_shot_trigger <= 1'b0;
			run_enable <= 1'b0;
			shot_kick <= 1'b0;
			if (boot_cnt == 8'(`AMC_BOOT_CYCLES - 1)) begin
				boot_req <= 1'b0;
			end
		end else if (wr_ctrl) begin
			// Fields steer the sequencer directly
			height_mode_select <= bus_if.wdata[`AMC_CTRL_HEIGHT];
			oversample_field <=
				bus_if.wdata[`AMC_CTRL_OS_HI:`AMC_CTRL_OS_LO];
			single_shot_trigger <= bus_if.wdata[`AMC_CTRL_SHOT];
			run_enable <= bus_if.wdata[`AMC_CTRL_RUN];
			if (bus_if.wdata[`AMC_CTRL_REBOOT]) begin
				boot_req <= 1'b1;
			end
			if (bus_if.wdata[`AMC_CTRL_SHOT] && !single_shot_trigger) begin
				shot_kick <= 1'b1;
			end
		end else begin
			// Hardware clears
			if (shot_clear) begin
				single_shot_trigger <= 1'b0;
			end
			if (boot_req && ready_state) begin
				run_enable <= 1'b0;
			end
			if (meas_start_out) begin
				shot_kick <= 1'b0;
			end
		end
	end

	// ****************************************************
	// Sequencer
	// ****************************************************
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= amc_pkg::AMC_STANDBY;
			elapsed <= 48'h0;
			boot_cnt <= 8'h00;
			oneshot_sb <= 1'b0;
			meas_start_out <= 1'b0;
		end else begin
			meas_start_out <= 1'b0;
			elapsed <= elapsed + 48'h1;
			case (state)
				amc_pkg::AMC_STANDBY: begin
					if (boot_req) begin
						state <= amc_pkg::AMC_REBOOT;
						boot_cnt <= 8'h00;
					end else if (run_enable) begin
						// Going active measures at once
						state <= amc_pkg::AMC_MEASURE;
						meas_start_out <= 1'b1;
						elapsed <= 48'h0;
						oneshot_sb <= 1'b0;
					end else if (single_shot_trigger) begin
						state <= amc_pkg::AMC_MEASURE;
						meas_start_out <= 1'b1;
						elapsed <= 48'h0;
						oneshot_sb <= 1'b1;
					end
				end
				amc_pkg::AMC_ACTIVE: begin
					if (boot_req || !run_enable) begin
						state <= amc_pkg::AMC_STANDBY;
					end else if (shot_kick
						|| elapsed >= interval_cycles) begin
						state <= amc_pkg::AMC_MEASURE;
						meas_start_out <= 1'b1;
						elapsed <= 48'h0;
					end
				end
				amc_pkg::AMC_MEASURE: begin
					if (meas_done_in) begin
						state <= amc_pkg::AMC_SPACING;
					end
				end
				amc_pkg::AMC_SPACING: begin
					// Hold off until the oversample spacing passed
					if (elapsed >= spacing_cycles) begin
						if (oneshot_sb || !run_enable) begin
							state <= amc_pkg::AMC_STANDBY;
						end else begin
							state <= amc_pkg::AMC_ACTIVE;
						end
						oneshot_sb <= 1'b0;
					end
				end
				default: begin
					boot_cnt <= boot_cnt + 8'h01;
					if (boot_cnt == 8'(`AMC_BOOT_CYCLES - 1)) begin
						state <= amc_pkg::AMC_STANDBY;
					end
				end
			endcase
		end
	end

	// Registered mode outputs
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_active_out <= 1'b0;
			oversample_ratio_out <= 8'h01;
		end else begin
			run_active_out <= (state == amc_pkg::AMC_MEASURE)
				|| (state == amc_pkg::AMC_SPACING)
				|| (state == amc_pkg::AMC_ACTIVE);
			oversample_ratio_out <= 8'h01 << oversample_field;
		end
	end

	// ****************************************************
	// Peak temperature
	// ****************************************************
	// A new peak wins over a host write in the same cycle
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			peak_hi <= `AMC_PEAK_RESET;
			peak_lo <= 4'h0;
		end else if (state == amc_pkg::AMC_REBOOT) begin
			peak_hi <= `AMC_PEAK_RESET;
			peak_lo <= 4'h0;
		end else if (peak_take) begin
			peak_hi <= meas_temp_in[11:4];
			peak_lo <= meas_temp_in[3:0];
		end else if (bus_if.wr && bus_if.addr == `AMC_ADDR_PEAK_HI) begin
			peak_hi <= bus_if.wdata;
		end else if (bus_if.wr && bus_if.addr == `AMC_ADDR_PEAK_LO) begin
			peak_lo <= bus_if.wdata[`AMC_PEAK_FRAC_HI:`AMC_PEAK_FRAC_LO];
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking amc_cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence standby_shot_s;
		state == amc_pkg::AMC_STANDBY && single_shot_trigger
			&& !boot_req && !run_enable;
	endsequence
	sequence measure_go_s;
		state == amc_pkg::AMC_MEASURE && meas_start_out;
	endsequence
	sequence boot_end_s;
		state == amc_pkg::AMC_REBOOT ##1 state == amc_pkg::AMC_STANDBY;
	endsequence

	read_reserved_a: assert property (
		bus_if.addr == `AMC_ADDR_PEAK_LO |-> bus_if.rdata[3:0] == 4'h0)
		else $error("peak low reserved bits not zero");
	peak_clear_a: assert property (
		bus_if.wr && bus_if.addr == `AMC_ADDR_PEAK_HI
		&& bus_if.wdata == 8'h00 && !peak_take
		&& state != amc_pkg::AMC_REBOOT |=> peak_hi == 8'h00)
		else $error("zero write did not clear peak");
	peak_take_a: assert property (
		peak_take && state != amc_pkg::AMC_REBOOT
		|=> {peak_hi, peak_lo} == $past(meas_temp_in))
		else $error("higher reading not captured");
	height_sel_a: assert property (
		wr_ctrl && state != amc_pkg::AMC_REBOOT
		|=> height_mode_out == $past(bus_if.wdata[7]))
		else $error("height mode not taken from write");
	ratio_a: assert property (
		wr_ctrl && state != amc_pkg::AMC_REBOOT ##1
		state != amc_pkg::AMC_REBOOT && !wr_ctrl
		|=> oversample_ratio_out == (8'h01 << $past(bus_if.wdata[5:3], 2)))
		else $error("oversample ratio wrong");
	spacing_hold_a: assert property (
		state == amc_pkg::AMC_SPACING && elapsed < spacing_cycles
		|=> state == amc_pkg::AMC_SPACING)
		else $error("spacing left too early");
	reboot_read_a: assert property (
		bus_if.addr == `AMC_ADDR_CTRL1 |-> bus_if.rdata[2] == 1'b0)
		else $error("reboot bit read back as one");
	active_boot_a: assert property (
		state == amc_pkg::AMC_ACTIVE && boot_req
		|=> state == amc_pkg::AMC_STANDBY ##1 state == amc_pkg::AMC_REBOOT)
		else $error("active reboot skipped standby");
	boot_end_a: assert property (
		boot_end_s |-> !boot_req && ctrl_view == `AMC_CTRL_RESET
		&& peak_hi == 8'h00 && peak_lo == 4'h0)
		else $error("reboot left state behind");
	serial_hold_a: assert property (
		state == amc_pkg::AMC_REBOOT ##1 state == amc_pkg::AMC_REBOOT
		|-> !sda_oe_out && !bus_if.wr)
		else $error("serial logic active during reboot");
	active_shot_a: assert property (
		state == amc_pkg::AMC_ACTIVE && shot_kick && run_enable
		&& !boot_req |=> measure_go_s)
		else $error("active one-shot did not start");
	standby_shot_a: assert property (
		standby_shot_s |=> measure_go_s)
		else $error("standby one-shot did not start");
	period_a: assert property (
		state == amc_pkg::AMC_ACTIVE && run_enable && !boot_req
		&& !shot_kick && elapsed < interval_cycles |=> !meas_start_out)
		else $error("periodic start came early");
endmodule : amc_top

//--- logic/amc_defs.svh
// Register map, field positions, reset values and timing constants
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH
// Register pointers on the serial link
`define AMC_ADDR_PEAK_HI 8'h24
`define AMC_ADDR_PEAK_LO 8'h25
`define AMC_ADDR_CTRL1 8'h26
// Control word one fields
`define AMC_CTRL_HEIGHT 7
`define AMC_CTRL_OS_HI 5
`define AMC_CTRL_OS_LO 3
`define AMC_CTRL_REBOOT 2
`define AMC_CTRL_SHOT 1
`define AMC_CTRL_RUN 0
`define AMC_CTRL_RESET 8'h00
// Peak temperature fields
`define AMC_PEAK_FRAC_HI 7
`define AMC_PEAK_FRAC_LO 4
`define AMC_PEAK_RESET 8'h00
`define AMC_READ_ZERO 8'h00
// Timing
`define AMC_CLK_HZ 50000000
`define AMC_MS_PER_S 1000
`define AMC_STEP_BASE_S 1
`define AMC_SPACE_MS_0 6
`define AMC_SPACE_MS_1 10
`define AMC_SPACE_MS_2 18
`define AMC_SPACE_MS_3 34
`define AMC_SPACE_MS_4 66
`define AMC_SPACE_MS_5 130
`define AMC_SPACE_MS_6 258
`define AMC_SPACE_MS_7 512
`define AMC_BOOT_CYCLES 16
// Serial slave
`define AMC_I2C_ADDR_DEF 7'h3A
`define AMC_BIT_LAST 4'h7
`define AMC_BIT_ACK 4'h8
`endif

//--- logic/amc_pkg.sv
// Types shared by the acquisition control block
package amc_pkg;
	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		AMC_STANDBY = 5'b00001,
		AMC_MEASURE = 5'b00010,
		AMC_SPACING = 5'b00100,
		AMC_ACTIVE = 5'b01000,
		AMC_REBOOT = 5'b10000
	} amc_state_t;
	// Serial slave states, one-hot
	typedef enum logic [4:0] {
		AMC_SL_IDLE = 5'b00001,
		AMC_SL_ADDR = 5'b00010,
		AMC_SL_PTR = 5'b00100,
		AMC_SL_WR = 5'b01000,
		AMC_SL_RD = 5'b10000
	} amc_sl_state_t;
endpackage : amc_pkg

//--- logic/amc_if.sv
// Register access carrier between serial slave and register file
`timescale 1ns/1ps
interface amc_if;
	logic wr; // One-cycle write strobe
	logic [7:0] addr; // Register pointer
	logic [7:0] wdata; // Write byte
	logic [7:0] rdata; // Read byte for addr
	logic soft_rst; // Holds the slave in reset
	modport slave(output wr, addr, wdata, input rdata, soft_rst);
	modport regs(input wr, addr, wdata, output rdata, soft_rst);
endinterface : amc_if

//--- logic/amc_i2c.sv
// Serial register-access slave, oversampling clock and data lines
`timescale 1ns/1ps
`include "amc_defs.svh"
module amc_i2c #(
	parameter logic [6:0] DEV_ADDR = `AMC_I2C_ADDR_DEF
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Link pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Register side
	amc_if.slave bus
);
	logic [1:0] scl_sync; // Two-stage synchroniser
	logic [1:0] sda_sync; // Two-stage synchroniser
	logic scl_d; // Previous synchronised clock
	logic sda_d; // Previous synchronised data
	logic scl_rise, scl_fall, start_seen, stop_seen;
	amc_pkg::amc_sl_state_t state; // Transfer phase
	logic [3:0] cnt; // Bit index, 8 is the ack slot
	logic [7:0] rx; // Receive shifter
	logic [7:0] tx; // Transmit shifter
	logic [7:0] ptr; // Register pointer
	logic rnw; // Read requested
	logic master_ack; // Host acked last read byte
	logic bit_open; // A clock rise came since the last handled fall

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign bus.addr = ptr;

	// Synchronise pins, then keep one more stage for edges
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
		end
	end

	assign scl_rise = scl_sync[1] & ~scl_d;
	assign scl_fall = ~scl_sync[1] & scl_d;
	assign start_seen = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign stop_seen = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	// Byte engine; soft reset drops any half-done transfer
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= amc_pkg::AMC_SL_IDLE;
			cnt <= 4'h0;
			rx <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			rnw <= 1'b0;
			master_ack <= 1'b0;
			sda_oe_out <= 1'b0;
			bus.wr <= 1'b0;
			bus.wdata <= 8'h00;
			bit_open <= 1'b0;
		end else if (bus.soft_rst) begin
			state <= amc_pkg::AMC_SL_IDLE;
			cnt <= 4'h0;
			rx <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			rnw <= 1'b0;
			master_ack <= 1'b0;
			sda_oe_out <= 1'b0;
			bus.wr <= 1'b0;
			bus.wdata <= 8'h00;
			bit_open <= 1'b0;
		end else begin
			bus.wr <= 1'b0;
			if (start_seen) begin
				// The clock fall that ends a start carries no bit
				state <= amc_pkg::AMC_SL_ADDR;
				cnt <= 4'h0;
				sda_oe_out <= 1'b0;
				bit_open <= 1'b0;
			end else if (stop_seen) begin
				state <= amc_pkg::AMC_SL_IDLE;
				sda_oe_out <= 1'b0;
			end else if (scl_rise && state != amc_pkg::AMC_SL_IDLE) begin
				// Sample data bits, or the host's ack after a read byte
				bit_open <= 1'b1;
				if (cnt != `AMC_BIT_ACK) begin
					rx <= {rx[6:0], sda_sync[1]};
				end else begin
					master_ack <= ~sda_sync[1];
				end
			end else if (scl_fall && bit_open
				&& state != amc_pkg::AMC_SL_IDLE) begin
				// Only a fall that closes a sampled bit moves the count
				bit_open <= 1'b0;
				if (cnt == `AMC_BIT_LAST) begin
					// Byte done: ack it, or release after a sent byte
					cnt <= `AMC_BIT_ACK;
					case (state)
						amc_pkg::AMC_SL_ADDR: begin
							if (rx[7:1] == DEV_ADDR) begin
								sda_oe_out <= 1'b1;
								rnw <= rx[0];
							end else begin
								state <= amc_pkg::AMC_SL_IDLE;
							end
						end
						amc_pkg::AMC_SL_PTR: begin
							ptr <= rx;
							sda_oe_out <= 1'b1;
						end
						amc_pkg::AMC_SL_WR: begin
							bus.wr <= 1'b1;
							bus.wdata <= rx;
							sda_oe_out <= 1'b1;
						end
						default: begin
							sda_oe_out <= 1'b0;
							ptr <= ptr + 8'h01;
						end
					endcase
				end else if (cnt == `AMC_BIT_ACK) begin
					// Ack slot over: pick the next phase
					cnt <= 4'h0;
					sda_oe_out <= 1'b0;
					case (state)
						amc_pkg::AMC_SL_ADDR: begin
							if (rnw) begin
								state <= amc_pkg::AMC_SL_RD;
								tx <= bus.rdata;
								sda_oe_out <= ~bus.rdata[7];
							end else begin
								state <= amc_pkg::AMC_SL_PTR;
							end
						end
						amc_pkg::AMC_SL_PTR: state <= amc_pkg::AMC_SL_WR;
						amc_pkg::AMC_SL_WR: ptr <= ptr + 8'h01;
						default: begin
							if (master_ack) begin
								tx <= bus.rdata;
								sda_oe_out <= ~bus.rdata[7];
							end else begin
								state <= amc_pkg::AMC_SL_IDLE;
							end
						end
					endcase
				end else begin
					// Next data bit, MSB first on reads
					cnt <= cnt + 4'h1;
					if (state == amc_pkg::AMC_SL_RD) begin
						sda_oe_out <= ~tx[6];
						tx <= {tx[6:0], 1'b0};
					end
				end
			end
		end
	end
endmodule : amc_i2c

//--- tb/amc_host.sv
// Serial host model: drives the link clock and pulls the data line low
`timescale 1ns/1ps
`include "amc_defs.svh"
module amc_host (
	// Clock and wired data line
	input wire logic clk_in,
	input wire logic sda_in,
	// Link drive
	output logic scl_out,
	output logic sda_low_out
);
	int nacks = 0; // Bytes the device left unacknowledged
	// Link clock stands high between frames, data released
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Quarter of the 160 ns link period
	task automatic quarter;
		repeat (2) @(posedge clk_in);
	endtask : quarter
	// One bit: data set while clock low, sampled while clock high
	task automatic bit_x(input logic b, output logic r);
		sda_low_out <= !b;
		quarter;
		scl_out <= 1'b1;
		quarter;
		r = sda_in;
		quarter;
		scl_out <= 1'b0;
		quarter;
	endtask : bit_x
	// Start or repeated start: data falls while clock high
	task automatic start;
		sda_low_out <= 1'b0;
		quarter;
		scl_out <= 1'b1;
		quarter;
		sda_low_out <= 1'b1;
		quarter;
		scl_out <= 1'b0;
		quarter;
	endtask : start
	// Stop: data rises while clock high
	task automatic stop;
		sda_low_out <= 1'b1;
		quarter;
		scl_out <= 1'b1;
		quarter;
		sda_low_out <= 1'b0;
		quarter;
	endtask : stop
	// One byte, MSB first; the host always releases the ninth bit
	task automatic xfer(input logic [7:0] d, input logic rd,
		output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
		bit_x(1'b1, a);
		if (!rd && a) begin
			nacks++;
		end
	endtask : xfer
	// Register write of one byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		start;
		xfer({`AMC_I2C_ADDR_DEF, 1'b0}, 1'b0, r);
		xfer(a, 1'b0, r);
		xfer(d, 1'b0, r);
		stop;
	endtask : wr
	// Register read of one byte, ended by a host not-acknowledge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		start;
		xfer({`AMC_I2C_ADDR_DEF, 1'b0}, 1'b0, d);
		xfer(a, 1'b0, d);
		start;
		xfer({`AMC_I2C_ADDR_DEF, 1'b1}, 1'b0, d);
		xfer(8'hFF, 1'b1, d);
		stop;
	endtask : rd
endmodule : amc_host

//--- tb/tb.sv
// Self-checking bench for the acquisition control block
`timescale 1ns/1ps
module tb;
	// ****************
	// Signals
	// ****************
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [3:0] exp_q = 4'h0; // Step exponent
	logic [11:0] temp = 12'h000; // Engine reading
	logic [3:0] eng = 4'h0; // Engine delay line, done 4 cycles after start
	logic scl, sda_low, sda_oe, start_p, run_act, height, booting, sda_drv;
	logic [7:0] ratio, v;
	wire logic sda_line = !(sda_low || sda_oe); // Pull-up when released
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0, last_start = 0, gap = 0, run_len = 0;
	int sp[8] = '{6, 10, 18, 34, 66, 130, 258, 512}; // Spacing in ms
	amc_top #(.MS_CYCLES(10), .S_CYCLES(200)) amc_top_i (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_drv),
		.sda_oe_out(sda_oe), .acquisition_interval_exp_in(exp_q),
		.meas_done_in(eng[3]), .meas_temp_in(temp), .meas_start_out(start_p),
		.run_active_out(run_act), .height_mode_out(height),
		.oversample_ratio_out(ratio), .booting_out(booting));
	amc_host amc_host_i (.clk_in(clock_in), .sda_in(sda_line),
		.scl_out(scl), .sda_low_out(sda_low));
	initial begin
		forever #10 clock_in = ~clock_in;
	end
	// Measurement engine answers each start
	always @(posedge clock_in) begin
		eng <= {eng[2:0], start_p};
	end
	// Observer: active length and spacing of starts
	always @(negedge clock_in) begin
		cyc++;
		if (run_act) run_len++;
		if (start_p) begin
			gap = cyc - last_start;
			last_start = cyc;
		end
	end
	// ****************
	// Helpers
	// ****************
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait until measuring and rebooting are over
	task settle(input int lim);
		for (int i = 0; i < lim && (run_act !== 1'b0 || booting !== 1'b0); i++)
			@(negedge clock_in);
	endtask : settle
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// ****************
	// Scenarios
	// ****************
	task t_reset;
		chk(ratio, 8'h01);
		chk({run_act, height, booting}, 8'h00);
		chk(8'(sda_drv), 8'h00);
		for (int a = 8'h24; a <= 8'h26; a++) begin
			amc_host_i.rd(8'(a), v);
			chk(v, 8'h00);
		end
	endtask : t_reset
	task t_fields;
		for (int k = 0; k < 8; k++) begin
			amc_host_i.wr(8'h26, 8'h80 | 8'(k << 3));
			@(negedge clock_in);
			chk(ratio, 8'h01 << k);
			chk(8'(height), 8'h01);
			amc_host_i.rd(8'h26, v);
			chk(v, 8'h80 | 8'(k << 3));
		end
		amc_host_i.wr(8'h26, 8'h00);
		@(negedge clock_in);
		chk(8'(height), 8'h00);
		amc_host_i.rd(8'h26, v);
		chk(v, 8'h00);
	endtask : t_fields
	task t_shot;
		for (int k = 0; k < 8; k++) begin
			@(posedge clock_in);
			temp <= 12'(12'h100 + k);
			run_len = 0;
			amc_host_i.wr(8'h26, 8'(k << 3) | 8'h02);
			settle(6000);
			chk(8'(run_len + 1 >= sp[k] * 10), 8'h01);
			chk(8'(run_len <= sp[k] * 10 + 2), 8'h01);
			amc_host_i.rd(8'h26, v);
			chk(v, 8'(k << 3));
		end
		amc_host_i.rd(8'h24, v);
		chk(v, 8'h10);
		amc_host_i.rd(8'h25, v);
		chk(v, 8'h70);
	endtask : t_shot
	task t_peak;
		@(posedge clock_in);
		temp <= 12'h0A5;
		amc_host_i.wr(8'h26, 8'h02);
		settle(200);
		amc_host_i.rd(8'h26, v);
		chk(v, 8'h00);
		amc_host_i.rd(8'h24, v);
		chk(v, 8'h10);
		amc_host_i.wr(8'h25, 8'hFF);
		amc_host_i.rd(8'h25, v);
		chk(v, 8'hF0);
		amc_host_i.wr(8'h24, 8'h00);
		amc_host_i.wr(8'h25, 8'h00);
		amc_host_i.rd(8'h24, v);
		chk(v, 8'h00);
		amc_host_i.rd(8'h25, v);
		chk(v, 8'h00);
	endtask : t_peak
	task t_active;
		@(posedge clock_in);
		exp_q <= 4'h1;
		amc_host_i.wr(8'h26, 8'h01);
		repeat (900) @(negedge clock_in);
		chk(8'(gap >= 400 && gap <= 401), 8'h01);
		chk(8'(run_act), 8'h01);
		amc_host_i.rd(8'h26, v);
		chk(v, 8'h01);
		amc_host_i.wr(8'h26, 8'h03);
		repeat (80) @(negedge clock_in);
		chk(8'(gap < 400), 8'h01);
		amc_host_i.rd(8'h26, v);
		chk(v, 8'h03);
		amc_host_i.rd(8'h24, v);
		chk(v, 8'h0A);
	endtask : t_active
	task t_reboot;
		// Reboot requested while active
		amc_host_i.wr(8'h26, 8'h05);
		settle(500);
		chk({run_act, booting}, 8'h00);
		amc_host_i.rd(8'h26, v);
		chk(v, 8'h00);
		amc_host_i.rd(8'h24, v);
		chk(v, 8'h00);
		// Reboot requested in standby, with fields to be undone
		amc_host_i.wr(8'h24, 8'h33);
		amc_host_i.wr(8'h26, 8'h84);
		chk(8'(booting), 8'h01);
		settle(500);
		chk({run_act, height, booting}, 8'h00);
		amc_host_i.rd(8'h24, v);
		chk(v, 8'h00);
		amc_host_i.rd(8'h26, v);
		chk(v, 8'h00);
		chk(8'(amc_host_i.nacks), 8'h00);
	endtask : t_reboot
	// Main sequence after two cycles of reset
	initial begin
		repeat (2) @(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		t_reset;
		t_fields;
		t_shot;
		t_peak;
		t_active;
		t_reboot;
		tally_and_finish;
	end
	// Watchdog, about three and a half times the expected run
	initial begin
		#2000000;
		fail_count++;
		tally_and_finish;
	end
endmodule : tb
